// [bench/ufoj_core_checker.sv]
// Concurrent checks on the ports of the unary file ops and jump core.
`timescale 1ns/1ps
module ufoj_core_checker
  import ufoj_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 instr_valid_in,
  input  wire logic [UFOJ_IW-1:0]   instr_in,
  input  wire logic [UFOJ_DW-1:0]   file_rdata_in,
  input  wire logic [UFOJ_DW-1:0]   upper_jump_latch_in,
  input  wire logic [UFOJ_FW-1:0]   file_raddr_out,
  input  wire ufoj_file_wr_t        file_wr_out,
  input  wire logic [UFOJ_DW-1:0]   accumulator_out,
  input  wire logic                 zero_flag_out,
  input  wire logic [UFOJ_PCW-1:0]  program_counter_out,
  input  wire logic                 discard_cycle_out
);
  default clocking dcb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  wire logic [5:0] op  = instr_in[13:8];
  wire logic       ex  = instr_valid_in && !discard_cycle_out;
  wire logic       jmp = ex && instr_in[13:11] == UFOJ_OPC_JUMP;
  wire logic       skp = ex && (op == UFOJ_OPC_MINUS_SKIP || op == UFOJ_OPC_PLUS_SKIP);
  wire logic       dec = op == UFOJ_OPC_MINUS_ONE || op == UFOJ_OPC_MINUS_SKIP;
  wire logic       alu = ex && (op == UFOJ_OPC_INVERT || op == UFOJ_OPC_MINUS_ONE
                                || op == UFOJ_OPC_PLUS_ONE);
  wire logic [7:0] res = op == UFOJ_OPC_INVERT ? ~file_rdata_in
                       : dec ? file_rdata_in - 8'h01 : file_rdata_in + 8'h01;
  wire logic       rz  = res == 8'h00;
  wire logic [12:0] tgt = {upper_jump_latch_in[4:3], instr_in[10:0]};
  sequence s_discard_slot;
    discard_cycle_out && instr_valid_in;
  endsequence
  property p_jump_target;
    jmp |=> program_counter_out == $past(tgt);
  endproperty
  chk_jump_target: assert property (p_jump_target) else $error("jump target wrong");
  chk_jump_discard: assert property (jmp |=> discard_cycle_out)
    else $error("jump did not discard next slot");
  chk_skip_discard: assert property (skp |=> discard_cycle_out == $past(rz))
    else $error("skip discard does not match result");
  chk_flag_kept: assert property ((jmp || skp) |=> $stable(zero_flag_out))
    else $error("zero flag changed by jump or skip");
  chk_discard_step: assert property (s_discard_slot |=> !discard_cycle_out
    && program_counter_out == $past(program_counter_out) + 13'h0001) else $error("bad discard");
  chk_write_back: assert property ((alu || skp) && instr_in[7] |=> file_wr_out.we
    && file_wr_out.addr == $past(file_raddr_out)) else $error("write back missing");
  chk_plus_acc: assert property (alu && op == UFOJ_OPC_PLUS_ONE && !instr_in[7]
    |=> accumulator_out == $past(file_rdata_in) + 8'h01) else $error("plus result wrong");
  chk_zero_update: assert property (alu |=> zero_flag_out == $past(rz))
    else $error("zero flag wrong");
  chk_acc_result: assert property ((alu || skp) && !instr_in[7]
    |=> accumulator_out == $past(res)) else $error("accumulator result wrong");
  chk_write_data: assert property ((alu || skp) && instr_in[7]
    |=> file_wr_out.data == $past(res)) else $error("write back data wrong");
endmodule : ufoj_core_checker

bind ufoj_core ufoj_core_checker u_chk (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .instr_valid_in(instr_valid_in),
  .instr_in(instr_in), .file_rdata_in(file_rdata_in), .upper_jump_latch_in(upper_jump_latch_in),
  .file_raddr_out(file_raddr_out), .file_wr_out(file_wr_out), .accumulator_out(accumulator_out),
  .zero_flag_out(zero_flag_out), .program_counter_out(program_counter_out),
  .discard_cycle_out(discard_cycle_out));

// [bench/ufoj_core_tb.sv]
// Self-checking corner and random bench of the unary file ops and jump core.
`timescale 1ns/1ps
module ufoj_core_tb
  import ufoj_pkg::*;
;
  logic                clk_sys_in = 1'b0;
  logic                rst_b_in = 1'b0;
  logic                instr_valid_in = 1'b0;
  logic [UFOJ_IW-1:0]  instr_in = 14'h0000;
  logic [UFOJ_DW-1:0]  file_rdata_in = 8'h00;
  logic [UFOJ_DW-1:0]  upper_jump_latch_in = 8'h00;
  logic [UFOJ_FW-1:0]  file_raddr_out, e_addr;
  ufoj_file_wr_t       file_wr_out;
  logic [UFOJ_DW-1:0]  accumulator_out, e_acc, e_data;
  logic                zero_flag_out, discard_cycle_out, e_zero, e_disc, e_we;
  logic [UFOJ_PCW-1:0] program_counter_out, e_pc;
  logic [31:0]         rng = 32'h00002d10;
  int                  bad_count = 0, n_compared = 0, cyc = 0;
  logic [5:0]          ops [8] = '{6'h09, 6'h03, 6'h0a, 6'h0b, 6'h0f, 6'h28, 6'h00, 6'h2f};
  logic [29:0]         cc [11] = '{{14'h0f11, 16'hff00}, {14'h0900, 16'h0000},
    {14'h0bff, 16'h0100}, {14'h0906, 16'h0000}, {14'h0305, 16'h0000}, {14'h0906, 16'hff00},
    {14'h0f07, 16'hfe00}, {14'h2fff, 16'h0018}, {14'h2800, 16'h00e7}, {14'h2800, 16'h00e7},
    {14'h0a80, 16'hff00}};

  always #5 clk_sys_in = ~clk_sys_in;

  ufoj_core DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .file_rdata_in(file_rdata_in), .upper_jump_latch_in(upper_jump_latch_in),
    .file_raddr_out(file_raddr_out), .file_wr_out(file_wr_out), .accumulator_out(accumulator_out),
    .zero_flag_out(zero_flag_out), .program_counter_out(program_counter_out),
    .discard_cycle_out(discard_cycle_out));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk

  task automatic compare();
    chk(file_raddr_out === instr_in[6:0], "raddr");
    chk(accumulator_out === e_acc, "acc");
    chk(zero_flag_out === e_zero, "zero");
    chk(program_counter_out === e_pc, "pc");
    chk(discard_cycle_out === e_disc, "discard");
    chk(file_wr_out.we === e_we, "we");
    if (e_we) chk(file_wr_out.data === e_data && file_wr_out.addr === e_addr, "wr");
  endtask : compare

  task automatic step();
    logic [5:0] o;
    logic [7:0] r;
    logic       sk;
    o  = instr_in[13:8];
    sk = o == UFOJ_OPC_MINUS_SKIP || o == UFOJ_OPC_PLUS_SKIP;
    r  = o == UFOJ_OPC_INVERT ? ~file_rdata_in
       : (o == UFOJ_OPC_MINUS_ONE || o == UFOJ_OPC_MINUS_SKIP) ? file_rdata_in - 8'h01
       : file_rdata_in + 8'h01;
    e_we = 1'b0;
    if (instr_valid_in) begin
      e_pc = e_pc + 13'h0001;
      if (e_disc) begin
        e_disc = 1'b0;
      end else if (instr_in[13:11] == UFOJ_OPC_JUMP) begin
        e_pc   = {upper_jump_latch_in[4:3], instr_in[10:0]};
        e_disc = 1'b1;
      end else if (sk || o == UFOJ_OPC_INVERT || o == UFOJ_OPC_MINUS_ONE
                   || o == UFOJ_OPC_PLUS_ONE) begin
        e_we   = instr_in[7];
        e_addr = instr_in[6:0];
        e_data = r;
        if (!instr_in[7]) e_acc = r;
        if (sk) e_disc = r == 8'h00;
        else e_zero = r == 8'h00;
      end
    end
  endtask : step

  task automatic drive(input logic v, input logic [13:0] i, input logic [7:0] d, input logic [7:0] l);
    @(posedge clk_sys_in);
    instr_valid_in      <= v;
    instr_in            <= i;
    file_rdata_in       <= d;
    upper_jump_latch_in <= l;
    @(negedge clk_sys_in);
    compare();
    step();
  endtask : drive

  task automatic do_reset();
    @(posedge clk_sys_in);
    rst_b_in       <= 1'b0;
    instr_valid_in <= 1'b0;
    @(negedge clk_sys_in);
    e_pc   = UFOJ_PC_RST;
    e_acc  = UFOJ_ACC_RST;
    e_zero = UFOJ_ZERO_RST;
    e_disc = 1'b0;
    e_we   = 1'b0;
    compare();
    @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
  endtask : do_reset

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    logic [31:0] d;
    repeat (3) @(posedge clk_sys_in);
    do_reset();
    foreach (cc[k]) drive(1'b1, cc[k][29:16], cc[k][15:8], cc[k][7:0]);
    $display("test corner done");
    for (int n = 0; n < 600; n++) begin
      rng = xs(rng);
      d   = rng;
      rng = xs(rng);
      drive(d[3:0] != 4'h0, ops[rng[2:0]][5:3] == UFOJ_OPC_JUMP ? {3'h5, rng[26:16]}
            : {ops[rng[2:0]], rng[31:24]}, d[9:8] == 2'b00 ? 8'hff : d[9:8] == 2'b01
            ? 8'h01 : d[31:24], d[23:16]);
    end
    $display("test random done");
    drive(1'b1, 14'h2fff, 8'h00, 8'h18);
    do_reset();
    drive(1'b1, 14'h0a00, 8'h7f, 8'h00);
    drive(1'b0, 14'h0000, 8'h00, 8'h00);
    $display("test reset done");
    finish_test();
  end

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      $display("MISMATCH t=%0t timeout", $time);
      finish_test();
    end
  end
endmodule : ufoj_core_tb

// [shared/ufoj_pkg.sv]
// Package with widths, encodings, reset values and carriers of the unary file ops and jump block.
package ufoj_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned UFOJ_IW      = 14;
  localparam int unsigned UFOJ_DW      = 8;
  localparam int unsigned UFOJ_FW      = 7;
  localparam int unsigned UFOJ_KW      = 11;
  localparam int unsigned UFOJ_PCW     = 13;
  localparam int unsigned UFOJ_OP_HI   = 13;
  localparam int unsigned UFOJ_OP_LO   = 8;
  localparam int unsigned UFOJ_JOP_LO  = 11;
  localparam int unsigned UFOJ_DST_BIT = 7;
  localparam int unsigned UFOJ_ULJ_HI  = 4;
  localparam int unsigned UFOJ_ULJ_LO  = 3;

  // ----------------------------------------------------------------
  // Opcode encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] UFOJ_OPC_INVERT     = 6'h09;
  localparam logic [5:0] UFOJ_OPC_MINUS_ONE  = 6'h03;
  localparam logic [5:0] UFOJ_OPC_PLUS_ONE   = 6'h0a;
  localparam logic [5:0] UFOJ_OPC_MINUS_SKIP = 6'h0b;
  localparam logic [5:0] UFOJ_OPC_PLUS_SKIP  = 6'h0f;
  localparam logic [2:0] UFOJ_OPC_JUMP       = 3'h5;

  // ----------------------------------------------------------------
  // Reset values and destination encoding
  // ----------------------------------------------------------------
  localparam logic [UFOJ_PCW-1:0] UFOJ_PC_RST   = 13'h0000;
  localparam logic [UFOJ_DW-1:0]  UFOJ_ACC_RST  = 8'h00;
  localparam logic                UFOJ_ZERO_RST = 1'b0;
  localparam logic                UFOJ_DST_ACC  = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UFOJ_ALU_PASS  = 3'h0,
    UFOJ_ALU_INV   = 3'h1,
    UFOJ_ALU_MINUS = 3'h2,
    UFOJ_ALU_PLUS  = 3'h3
  } ufoj_alu_op_t;

  typedef enum logic [1:0] {
    UFOJ_ST_EXEC    = 2'b01,
    UFOJ_ST_DISCARD = 2'b10
  } ufoj_state_t;

  typedef struct packed {
    logic               dest;
    logic [UFOJ_FW-1:0] faddr;
    logic [UFOJ_KW-1:0] imm;
  } ufoj_fields_t;

  typedef struct packed {
    logic               we;
    logic [UFOJ_FW-1:0] addr;
    logic [UFOJ_DW-1:0] data;
  } ufoj_file_wr_t;

endpackage : ufoj_pkg

// [verilog/ufoj_alu.sv]
// Eight-bit unary arithmetic unit with zero detect.
`timescale 1ns/1ps
module ufoj_alu
  import ufoj_pkg::*;
(
  input  wire ufoj_alu_op_t       op_in,
  input  wire logic [UFOJ_DW-1:0] operand_in,
  output logic      [UFOJ_DW-1:0] result_out,
  output logic                    zero_out
);

  localparam logic [UFOJ_DW-1:0] ONE = 8'h01;

  wire [UFOJ_DW-1:0] inv_w   = ~operand_in;
  wire [UFOJ_DW-1:0] minus_w = operand_in - ONE;
  wire [UFOJ_DW-1:0] plus_w  = operand_in + ONE;

  always_comb begin
    case (op_in)
      UFOJ_ALU_INV:   result_out = inv_w;
      UFOJ_ALU_MINUS: result_out = minus_w;
      UFOJ_ALU_PLUS:  result_out = plus_w;
      default:        result_out = operand_in;
    endcase
  end

  assign zero_out = (result_out == '0);

endmodule : ufoj_alu

// [verilog/ufoj_core.sv]
// Execution unit for invert, minus-one, plus-one, both skip variants and the absolute jump.
//
// Overview of operation
// - Invert-register writes the bitwise inverse of register 0..127, updating zero.
// - Destination bit 0 sends result to accumulator, 1 writes it back to register.
// - Minus-one-register subtracts one, writes selected destination, updates zero flag.
// - Plus-one-register adds one, writes selected destination, updates zero flag.
// - Jump loads immediate into counter bits 10:0, latch bits 4:3 into 12:11.
// - Jump is always taken and changes no status flag.
// - Jump takes two cycles; the second discards the already fetched instruction.
// - Minus-one-with-skip changes no flag; zero result makes next cycle a no-op.
// - Plus-one-with-skip changes no flag; zero result makes next cycle a no-op.
// - Nonzero skip result runs the next instruction; skip takes one cycle, two when a zero result discards the next.
`timescale 1ns/1ps
module ufoj_core
  import ufoj_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 instr_valid_in,
  input  wire logic [UFOJ_IW-1:0]   instr_in,
  input  wire logic [UFOJ_DW-1:0]   file_rdata_in,
  input  wire logic [UFOJ_DW-1:0]   upper_jump_latch_in,
  output logic      [UFOJ_FW-1:0]   file_raddr_out,
  output ufoj_file_wr_t             file_wr_out,
  output logic      [UFOJ_DW-1:0]   accumulator_out,
  output logic                      zero_flag_out,
  output logic      [UFOJ_PCW-1:0]  program_counter_out,
  output logic                      discard_cycle_out
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [UFOJ_PCW-1:0] PC_STEP = 13'h0001;

  // Bit range of the opcode field that the jump opcode occupies.
  localparam int unsigned OPC_TOP = UFOJ_OP_HI - UFOJ_OP_LO;
  localparam int unsigned OPC_JLO = UFOJ_JOP_LO - UFOJ_OP_LO;

  // A unary opcode that also matched the jump field would decode twice.
  localparam logic UNARY_HITS_JUMP =
    (UFOJ_OPC_INVERT[OPC_TOP:OPC_JLO]     == UFOJ_OPC_JUMP) ||
    (UFOJ_OPC_MINUS_ONE[OPC_TOP:OPC_JLO]  == UFOJ_OPC_JUMP) ||
    (UFOJ_OPC_PLUS_ONE[OPC_TOP:OPC_JLO]   == UFOJ_OPC_JUMP) ||
    (UFOJ_OPC_MINUS_SKIP[OPC_TOP:OPC_JLO] == UFOJ_OPC_JUMP) ||
    (UFOJ_OPC_PLUS_SKIP[OPC_TOP:OPC_JLO]  == UFOJ_OPC_JUMP);

  // Two unary instructions sharing one opcode could never both be reached.
  localparam logic UNARY_DUPLICATE =
    (UFOJ_OPC_INVERT     == UFOJ_OPC_MINUS_ONE)  ||
    (UFOJ_OPC_INVERT     == UFOJ_OPC_PLUS_ONE)   ||
    (UFOJ_OPC_INVERT     == UFOJ_OPC_MINUS_SKIP) ||
    (UFOJ_OPC_INVERT     == UFOJ_OPC_PLUS_SKIP)  ||
    (UFOJ_OPC_MINUS_ONE  == UFOJ_OPC_PLUS_ONE)   ||
    (UFOJ_OPC_MINUS_ONE  == UFOJ_OPC_MINUS_SKIP) ||
    (UFOJ_OPC_MINUS_ONE  == UFOJ_OPC_PLUS_SKIP)  ||
    (UFOJ_OPC_PLUS_ONE   == UFOJ_OPC_MINUS_SKIP) ||
    (UFOJ_OPC_PLUS_ONE   == UFOJ_OPC_PLUS_SKIP)  ||
    (UFOJ_OPC_MINUS_SKIP == UFOJ_OPC_PLUS_SKIP);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  ufoj_state_t   state_q;
  ufoj_state_t   state_d;
  ufoj_fields_t  fields_w;
  ufoj_alu_op_t  alu_op_w;
  ufoj_file_wr_t file_wr_q;
  ufoj_file_wr_t file_wr_d;

  logic [UFOJ_PCW-1:0] pc_q;
  logic [UFOJ_PCW-1:0] pc_d;
  logic [UFOJ_DW-1:0]  acc_q;
  logic [UFOJ_DW-1:0]  acc_d;
  logic                zero_q;
  logic                zero_d;
  logic [UFOJ_DW-1:0]  result_w;
  logic                result_zero_w;

  wire [5:0] opc_w  = instr_in[UFOJ_OP_HI:UFOJ_OP_LO];
  wire [2:0] jopc_w = instr_in[UFOJ_OP_HI:UFOJ_JOP_LO];

  assign fields_w.dest  = instr_in[UFOJ_DST_BIT];
  assign fields_w.faddr = instr_in[UFOJ_FW-1:0];
  assign fields_w.imm   = instr_in[UFOJ_KW-1:0];

  wire exec_w     = instr_valid_in && (state_q == UFOJ_ST_EXEC);
  wire discard_w  = instr_valid_in && (state_q == UFOJ_ST_DISCARD);
  wire is_inv_w   = exec_w && (opc_w == UFOJ_OPC_INVERT);
  wire is_minus_w = exec_w && (opc_w == UFOJ_OPC_MINUS_ONE);
  wire is_plus_w  = exec_w && (opc_w == UFOJ_OPC_PLUS_ONE);
  wire is_msk_w   = exec_w && (opc_w == UFOJ_OPC_MINUS_SKIP);
  wire is_psk_w   = exec_w && (opc_w == UFOJ_OPC_PLUS_SKIP);
  wire is_jump_w  = exec_w && (jopc_w == UFOJ_OPC_JUMP);

  wire is_skip_w  = is_msk_w || is_psk_w;
  wire is_unary_w = is_inv_w || is_minus_w || is_plus_w || is_skip_w;
  wire flag_upd_w = is_inv_w || is_minus_w || is_plus_w;
  wire to_file_w  = is_unary_w && (fields_w.dest != UFOJ_DST_ACC);
  wire to_acc_w   = is_unary_w && (fields_w.dest == UFOJ_DST_ACC);
  wire skip_hit_w = is_skip_w && result_zero_w;

  assign alu_op_w = is_inv_w                 ? UFOJ_ALU_INV   :
                    (is_minus_w || is_msk_w) ? UFOJ_ALU_MINUS :
                    (is_plus_w  || is_psk_w) ? UFOJ_ALU_PLUS  :
                                               UFOJ_ALU_PASS;

  wire [UFOJ_PCW-1:0] jump_target_w = {upper_jump_latch_in[UFOJ_ULJ_HI:UFOJ_ULJ_LO],
                                       fields_w.imm};

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  ufoj_alu u_alu (
    .op_in      (alu_op_w),
    .operand_in (file_rdata_in),
    .result_out (result_w),
    .zero_out   (result_zero_w)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      UFOJ_ST_EXEC: begin
        if (is_jump_w || skip_hit_w) begin
          state_d = UFOJ_ST_DISCARD;
        end
      end
      UFOJ_ST_DISCARD: begin
        if (discard_w) begin
          state_d = UFOJ_ST_EXEC;
        end
      end
      default: state_d = UFOJ_ST_EXEC;
    endcase
  end

  // The counter names the next fetch; a jump loads the target and the
  // discard cycle that follows steps past it like any other cycle.
  assign pc_d = is_jump_w      ? jump_target_w :
                instr_valid_in ? pc_q + PC_STEP :
                                 pc_q;

  assign acc_d  = to_acc_w   ? result_w      : acc_q;
  assign zero_d = flag_upd_w ? result_zero_w : zero_q;

  assign file_wr_d.we   = to_file_w;
  assign file_wr_d.addr = fields_w.faddr;
  assign file_wr_d.data = result_w;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q   <= UFOJ_ST_EXEC;
      pc_q      <= UFOJ_PC_RST;
      acc_q     <= UFOJ_ACC_RST;
      zero_q    <= UFOJ_ZERO_RST;
      file_wr_q <= '0;
    end else begin
      state_q   <= state_d;
      pc_q      <= pc_d;
      acc_q     <= acc_d;
      zero_q    <= zero_d;
      file_wr_q <= file_wr_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign file_raddr_out      = fields_w.faddr;
  assign file_wr_out         = file_wr_q;
  assign accumulator_out     = acc_q;
  assign zero_flag_out       = zero_q;
  assign program_counter_out = pc_q;
  assign discard_cycle_out   = (state_q == UFOJ_ST_DISCARD);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The decode above assumes that the package fields tile one instruction word.
  if (UFOJ_OP_HI != UFOJ_IW - 1) begin : g_bad_op_hi
    $error("Opcode field must end at the top bit of the instruction word.");
  end

  if (UFOJ_OP_HI - UFOJ_OP_LO + 1 != $bits(UFOJ_OPC_INVERT)) begin : g_bad_op_w
    $error("Opcode field width must match the unary opcode encodings.");
  end

  if (UFOJ_OP_HI - UFOJ_JOP_LO + 1 != $bits(UFOJ_OPC_JUMP)) begin : g_bad_jop_w
    $error("Jump opcode field width must match the jump encoding.");
  end

  if (UFOJ_JOP_LO != UFOJ_KW) begin : g_bad_imm
    $error("Jump immediate must fill the word below the jump opcode.");
  end

  if (UFOJ_DST_BIT != UFOJ_FW) begin : g_bad_dest
    $error("Destination bit must sit directly above the register field.");
  end

  if (UFOJ_DST_BIT >= UFOJ_OP_LO) begin : g_bad_dest_pos
    $error("Destination bit must lie below the opcode field.");
  end

  if (UFOJ_ULJ_HI >= UFOJ_DW || UFOJ_ULJ_HI < UFOJ_ULJ_LO) begin : g_bad_latch
    $error("Upper jump latch bits must form a range inside the latch.");
  end

  if (UFOJ_KW + UFOJ_ULJ_HI - UFOJ_ULJ_LO + 1 != UFOJ_PCW) begin : g_bad_pc_w
    $error("Immediate and latch bits must together fill the program counter.");
  end

  if (UNARY_HITS_JUMP) begin : g_bad_overlap
    $error("A unary opcode must not fall inside the jump opcode range.");
  end

  if (UNARY_DUPLICATE) begin : g_bad_dup
    $error("Unary opcodes must all be distinct.");
  end

  if ($countones(UFOJ_ST_EXEC) != 1 || $countones(UFOJ_ST_DISCARD) != 1) begin : g_bad_state
    $error("State codes must be one-hot.");
  end

endmodule : ufoj_core
